// *** logic/video_source.sv ***
// Parallel video source: drives pixel clock, syncs, data strobe,
// 24-bit pixel data and stereo eye flag into a display controller.
// Assumes pixel data from logic on sys_clk_in, always ready when taken.
`timescale 1ns/1ps
module video_source
   import video_src_pkg::*;
#(
   parameter int DIV       = PCLK_DIV,
   parameter int H_SYNC    = H_SYNC_DEF,
   parameter int H_BP      = H_BP_DEF,
   parameter int H_ACT     = H_ACT_DEF,
   parameter int H_FP      = H_FP_DEF,
   parameter int V_SYNC    = V_SYNC_DEF,
   parameter int V_BP      = V_BP_DEF,
   parameter int V_ACT     = V_ACT_DEF,
   parameter int V_FP      = V_FP_DEF,
   parameter int DISP_ACT  = V_ACT_DEF,
   parameter int SETUP_CYC = STEREO_SETUP_CYC,
   parameter int HOLD_CYC  = STEREO_HOLD_CYC
)(
   input  wire logic               sys_clk_in,
   input  wire logic               resetn_in,
   input  wire logic               run_in,
   input  wire logic               stereo_en_in,
   input  wire logic               vs_active_high_in,
   input  wire logic               hs_active_high_in,
   input  wire logic [PIXEL_W-1:0] pixel_data_in,
   output logic                    pixel_take_out,
   output logic                    pclk_out,
   output logic                    frame_sync_out,
   output logic                    line_sync_out,
   output logic                    active_pixel_strobe_out,
   output logic [PIXEL_W-1:0]      pixel_bus_out,
   output logic                    stereo_eye_flag_out
);
   localparam int H_TOT = H_BP + H_ACT + H_FP;
   localparam int V_TOT = V_BP + V_ACT + V_FP;
   localparam int HW    = $clog2(H_TOT + 1);
   localparam int VW    = $clog2(V_TOT + 1);
   localparam int SRC_OVER = (V_ACT > DISP_ACT) ? V_ACT : DISP_ACT;
   localparam logic [HW-1:0] H_LAST   = HW'(H_TOT - 1);
   localparam logic [VW-1:0] V_LAST   = VW'(V_TOT - 1);
   localparam logic [HW-1:0] H_SW     = HW'(H_SYNC);
   localparam logic [HW-1:0] H_DE_ON  = HW'(H_BP);
   localparam logic [HW-1:0] H_DE_OFF = HW'(H_BP + H_ACT);
   localparam logic [VW-1:0] V_SW     = VW'(V_SYNC);
   localparam logic [VW-1:0] V_ACT_ON = VW'(V_BP);
   localparam logic [VW-1:0] V_ACT_OFF = VW'(V_BP + V_ACT);
   localparam logic [VW-1:0] V_LAST_ACT = VW'(V_BP + V_ACT - 1);

   // Geometry checks that the generated stream meets the sink's limits
   if (V_SYNC < VSW_MIN || V_SYNC > V_BP)
      $error("video_source: V_SYNC must be 1 to V_BP lines");
   if (V_BP < VBP_MIN)
      $error("video_source: V_BP below minimum");
   if (V_FP < VFP_MIN)
      $error("video_source: V_FP below minimum");
   if (DISP_ACT < 1 || V_ACT < 1 ||
       (V_BP + V_FP - TVB_BASE) * DISP_ACT < TVB_SCALE * SRC_OVER)
      $error("video_source: vertical blanking too short");
   if (H_SYNC < HSW_MIN || H_SYNC > HSW_MAX)
      $error("video_source: H_SYNC out of range");
   if (H_BP < HBP_MIN || H_BP < H_SYNC || H_ACT < 1)
      $error("video_source: H_BP too short");
   if (H_FP < HFP_MIN)
      $error("video_source: H_FP too short");

   video_src_if bus ();

   pclk_divider #(
      .DIV       (DIV)
   ) u_div (
      .sys_clk_in (sys_clk_in),
      .resetn_in  (resetn_in),
      .bus        (bus.divider)
   );

   stereo_guard #(
      .SETUP_CYC (SETUP_CYC),
      .HOLD_CYC  (HOLD_CYC)
   ) u_guard (
      .sys_clk_in (sys_clk_in),
      .resetn_in  (resetn_in),
      .bus        (bus.guard)
   );

   gen_state_t          state_q;
   logic [HW-1:0]       h_q;
   logic [VW-1:0]       v_q;
   logic                vs_pol_q;
   logic                hs_pol_q;
   logic                want_eye_q;
   logic                frame_sync_q;
   logic                line_sync_q;
   logic                strobe_q;
   logic                take_q;
   logic [PIXEL_W-1:0]  pixel_q;
   logic                go;
   logic                run;
   logic                vs_act;
   logic                hs_act;
   logic                de_act;
   logic                vs_d;
   logic                hs_d;

   // A frame starts only when asked and the eye flag is settled
   assign go  = run_in && bus.frame_ok;
   assign run = (state_q == ST_RUN);

   // Active levels from the current counters, one launch ahead of pins
   assign vs_act = run && (v_q < V_SW);
   assign hs_act = run && (h_q < H_SW);
   assign de_act = run && (v_q >= V_ACT_ON) && (v_q < V_ACT_OFF) &&
                   (h_q >= H_DE_ON) && (h_q < H_DE_OFF);
   assign vs_d   = vs_act ~^ vs_pol_q;
   assign hs_d   = hs_act ~^ hs_pol_q;

   // Frame and line counters, advanced once per pixel clock
   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
      begin
         state_q <= ST_IDLE;
         h_q     <= '0;
         v_q     <= '0;
      end
      else if (bus.launch)
      begin
         case (state_q)
            ST_IDLE:
            begin
               h_q <= '0;
               v_q <= '0;
               if (go)
                  state_q <= ST_RUN;
            end
            ST_RUN:
            begin
               if (h_q != H_LAST)
                  h_q <= h_q + 1'b1;
               else
               begin
                  h_q <= '0;
                  if (v_q != V_LAST)
                     v_q <= v_q + 1'b1;
                  else
                  begin
                     // Front porch stretches while the eye flag settles
                     v_q <= '0;
                     if (!go)
                        state_q <= ST_IDLE;
                  end
               end
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // Polarity is only picked up between frames
   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
      begin
         // Take the selection in reset so no false pulse follows it
         vs_pol_q <= vs_active_high_in;
         hs_pol_q <= hs_active_high_in;
      end
      else if (bus.launch && !run)
      begin
         vs_pol_q <= vs_active_high_in;
         hs_pol_q <= hs_active_high_in;
      end
   end

   // New eye request at start of the front porch, away from sync edges
   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
         want_eye_q <= 1'b0;
      else if (bus.launch && run && h_q == H_LAST && v_q == V_LAST_ACT)
         want_eye_q <= stereo_en_in ? ~want_eye_q : 1'b0;
   end

   // Pin registers update with the falling pixel clock edge
   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
      begin
         frame_sync_q <= ~vs_active_high_in;
         line_sync_q  <= ~hs_active_high_in;
         strobe_q     <= 1'b0;
         take_q       <= 1'b0;
         pixel_q      <= PIXEL_RST;
      end
      else
      begin
         take_q <= bus.launch && de_act;
         if (bus.launch)
         begin
            frame_sync_q <= vs_d;
            line_sync_q  <= hs_d;
            strobe_q     <= de_act;
            pixel_q      <= de_act ? pixel_data_in : PIXEL_RST;
         end
      end
   end

   assign bus.vs_change = bus.launch && (vs_d != frame_sync_q);
   assign bus.want_eye  = want_eye_q;

   assign pixel_take_out          = take_q;
   assign pclk_out                = bus.pclk;
   assign frame_sync_out          = frame_sync_q;
   assign line_sync_out           = line_sync_q;
   assign active_pixel_strobe_out = strobe_q;
   assign pixel_bus_out           = pixel_q;
   assign stereo_eye_flag_out     = bus.eye;
endmodule

// *** logic/video_src_pkg.sv ***
// Constants shared by the parallel video source controller.
// Assumes a 10 MHz system clock; the stereo guard cycle counts derive from it.
package video_src_pkg;
   localparam int  SYS_CLK_HZ      = 10_000_000;
   localparam int  PIXEL_W         = 24;
   // Pixel clock divider: system cycles per pixel clock
   localparam int  PCLK_DIV        = 8;
   localparam int  PCLK_DIV_MIN    = 4;
   // Horizontal limits in pixel clocks
   localparam int  HSW_MIN         = 4;
   localparam int  HSW_MAX         = 128;
   localparam int  HBP_MIN         = 4;
   localparam int  HFP_MIN         = 8;
   // Vertical limits in lines
   localparam int  VSW_MIN         = 1;
   localparam int  VBP_MIN         = 2;
   localparam int  VFP_MIN         = 1;
   localparam int  TVB_BASE        = 6;
   localparam int  TVB_SCALE       = 8;
   // Default frame geometry
   localparam int  H_SYNC_DEF      = 4;
   localparam int  H_BP_DEF        = 8;
   localparam int  H_ACT_DEF       = 64;
   localparam int  H_FP_DEF        = 8;
   localparam int  V_SYNC_DEF      = 1;
   localparam int  V_BP_DEF        = 8;
   localparam int  V_ACT_DEF       = 16;
   localparam int  V_FP_DEF        = 6;
   // Stereo flag spacing from any frame sync change
   localparam real STEREO_SETUP_MS = 1.0;
   localparam real STEREO_HOLD_MS  = 1.0;
   localparam int  STEREO_SETUP_CYC =
      int'($ceil(STEREO_SETUP_MS * 1.0e-3 * SYS_CLK_HZ));
   localparam int  STEREO_HOLD_CYC  =
      int'($ceil(STEREO_HOLD_MS * 1.0e-3 * SYS_CLK_HZ));
   // Polarity select reset value: active high
   localparam logic POL_HIGH_RST   = 1'b1;
   localparam logic [PIXEL_W-1:0] PIXEL_RST = 24'h000000;

   typedef enum logic {ST_IDLE, ST_RUN} gen_state_t;
endpackage

// *** logic/video_src_if.sv ***
// Internal carrier between timing generator, pixel clock divider and
// stereo guard. All signals are on the system clock.
`timescale 1ns/1ps
interface video_src_if;
   logic pclk;
   logic launch;
   logic vs_change;
   logic want_eye;
   logic eye;
   logic frame_ok;

   modport divider (output pclk, output launch);
   modport guard   (input vs_change, input want_eye,
                    output eye, output frame_ok);
   modport timing  (input pclk, input launch, input eye, input frame_ok,
                    output vs_change, output want_eye);
endinterface

// *** logic/pclk_divider.sv ***
// Pixel clock divider: makes the pixel clock from the system clock.
// Launch pulses in the cycle before the falling edge, so data moves
// half a period away from the rising (sampling) edge.
`timescale 1ns/1ps
module pclk_divider
   import video_src_pkg::*;
#(
   parameter int DIV = PCLK_DIV
)(
   input  wire logic   sys_clk_in,
   input  wire logic   resetn_in,
   video_src_if.divider bus
);
   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);
   localparam logic [CW-1:0] HALF = CW'(DIV / 2);

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          pclk_q;
   logic          launch_q;

   if (DIV < PCLK_DIV_MIN || (DIV % 2) != 0)
      $error("pclk_divider: DIV must be even and at least 4");

   assign cnt_d = (cnt_q == LAST) ? '0 : cnt_q + 1'b1;

   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
      begin
         cnt_q    <= '0;
         pclk_q   <= 1'b0;
         launch_q <= 1'b0;
      end
      else
      begin
         cnt_q    <= cnt_d;
         pclk_q   <= (cnt_d >= HALF);
         launch_q <= (cnt_d == LAST);
      end
   end

   assign bus.pclk   = pclk_q;
   assign bus.launch = launch_q;
endmodule

// *** logic/stereo_guard.sv ***
// Stereo eye flag guard: moves the flag only well clear of frame sync
// changes and tells the timing generator when a frame may start.
`timescale 1ns/1ps
module stereo_guard
   import video_src_pkg::*;
#(
   parameter int SETUP_CYC = STEREO_SETUP_CYC,
   parameter int HOLD_CYC  = STEREO_HOLD_CYC
)(
   input  wire logic  sys_clk_in,
   input  wire logic  resetn_in,
   video_src_if.guard bus
);
   localparam int MAXC = (SETUP_CYC > HOLD_CYC) ? SETUP_CYC : HOLD_CYC;
   localparam int W    = $clog2(MAXC + 1);
   localparam logic [W-1:0] SAT   = W'(MAXC);
   localparam logic [W-1:0] SETUP = W'(SETUP_CYC);
   localparam logic [W-1:0] HOLD  = W'(HOLD_CYC);

   logic [W-1:0] since_vs_q;
   logic [W-1:0] since_eye_q;
   logic         eye_q;
   logic         move;

   if (SETUP_CYC < 1 || HOLD_CYC < 1)
      $error("stereo_guard: guard counts must be at least 1");

   // Flag may move only once the last frame sync change is old enough
   assign move = (bus.want_eye != eye_q) && (since_vs_q >= HOLD);

   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
         since_vs_q <= SAT;
      else if (bus.vs_change)
         since_vs_q <= '0;
      else if (since_vs_q != SAT)
         since_vs_q <= since_vs_q + 1'b1;
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
      begin
         eye_q       <= 1'b0;
         since_eye_q <= SAT;
      end
      else if (move)
      begin
         eye_q       <= bus.want_eye;
         since_eye_q <= '0;
      end
      else if (since_eye_q != SAT)
         since_eye_q <= since_eye_q + 1'b1;
   end

   assign bus.eye      = eye_q;
   // Frame sync may change only long after the flag settled
   assign bus.frame_ok = (bus.want_eye == eye_q) &&
                         (since_eye_q >= SETUP);
endmodule

// *** tb/video_source_checker.sv ***
// Pin checker for the parallel video source.
// Bound to video_source; all counts are system clock cycles.
`timescale 1ns/1ps
module video_source_checker
   import video_src_pkg::*;
#(
   parameter int DIV        = 8,
   parameter int LINE_PCLKS = 24,
   parameter int SETUP_CYC  = 50,
   parameter int HOLD_CYC   = 50
)(
   input wire logic               sys_clk_in,
   input wire logic               resetn_in,
   input wire logic               vs_active_high_in,
   input wire logic               hs_active_high_in,
   input wire logic               pixel_take_out,
   input wire logic               pclk_out,
   input wire logic               frame_sync_out,
   input wire logic               line_sync_out,
   input wire logic               active_pixel_strobe_out,
   input wire logic [PIXEL_W-1:0] pixel_bus_out,
   input wire logic               stereo_eye_flag_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);
   logic        hs_act;
   logic        vs_act;
   logic [31:0] hs_cnt_q, vs_cnt_q, hs_age_q, de_age_q, vs_age_q, eye_age_q;
   assign hs_act = (line_sync_out == hs_active_high_in);
   assign vs_act = (frame_sync_out == vs_active_high_in);
   // Reset values let a pulse cut short by reset pass
   always_ff @(posedge sys_clk_in)
   begin
      hs_cnt_q <= !resetn_in ? 32'h20 : hs_act ? hs_cnt_q + 1 : 32'h0;
      vs_cnt_q <= !resetn_in ? 32'hfffff : vs_act ? vs_cnt_q + 1 : 32'h0;
      hs_age_q <= !resetn_in ? 32'hfffff : $rose(hs_act) ? 1 : hs_age_q + 1;
      de_age_q <= !resetn_in ? 32'hfffff :
                  $fell(active_pixel_strobe_out) ? 1 : de_age_q + 1;
      vs_age_q <= !resetn_in ? 32'hfffff :
                  $changed(frame_sync_out) ? 1 : vs_age_q + 1;
      eye_age_q <= !resetn_in ? 32'hfffff :
                   $changed(stereo_eye_flag_out) ? 1 : eye_age_q + 1;
   end
   pins_stable_a: assert property (
      !$stable({active_pixel_strobe_out, pixel_bus_out}) |-> $fell(pclk_out))
      else $error("data pins moved off the falling pixel clock");
   take_align_a: assert property (
      pixel_take_out |-> active_pixel_strobe_out && $fell(pclk_out))
      else $error("pixel take outside strobe");
   sync_align_a: assert property (
      $rose(vs_act) |-> $rose(hs_act) && $fell(pclk_out))
      else $error("frame sync not aligned to line sync");
   hs_width_a: assert property ($fell(hs_act) |->
      hs_cnt_q >= HSW_MIN * DIV && hs_cnt_q <= HSW_MAX * DIV)
      else $error("line sync width out of range");
   back_porch_a: assert property (
      $rose(active_pixel_strobe_out) |-> hs_age_q >= HBP_MIN * DIV)
      else $error("strobe too soon after line sync");
   front_porch_a: assert property (
      $rose(hs_act) |-> de_age_q >= HFP_MIN * DIV)
      else $error("line sync too soon after strobe");
   vs_width_a: assert property (
      $fell(vs_act) |-> vs_cnt_q >= LINE_PCLKS * DIV)
      else $error("frame sync shorter than a line");
   eye_hold_a: assert property (
      $changed(stereo_eye_flag_out) |-> vs_age_q >= HOLD_CYC)
      else $error("eye flag moved too soon after frame sync");
   eye_setup_a: assert property (
      $changed(frame_sync_out) |-> eye_age_q >= SETUP_CYC)
      else $error("frame sync moved too soon after eye flag");
endmodule

bind video_source video_source_checker #(
   .DIV(DIV), .LINE_PCLKS(H_BP + H_ACT + H_FP),
   .SETUP_CYC(SETUP_CYC), .HOLD_CYC(HOLD_CYC)
) u_checker (
   .sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
   .vs_active_high_in(vs_active_high_in),
   .hs_active_high_in(hs_active_high_in),
   .pixel_take_out(pixel_take_out), .pclk_out(pclk_out),
   .frame_sync_out(frame_sync_out), .line_sync_out(line_sync_out),
   .active_pixel_strobe_out(active_pixel_strobe_out),
   .pixel_bus_out(pixel_bus_out), .stereo_eye_flag_out(stereo_eye_flag_out)
);

// *** tb/video_sink.sv ***
// Display-side model: samples the video pins on pixel clock rise.
// Assumes pins come from the source on the same system clock.
`timescale 1ns/1ps
module video_sink #(
   parameter int SRC_LINES  = 4,
   parameter int DISP_LINES = 4
)(
   input  wire logic        sys_clk_in,
   input  wire logic        resetn_in,
   input  wire logic        vs_pol_in,
   input  wire logic        hs_pol_in,
   input  wire logic        pclk_in,
   input  wire logic        frame_sync_in,
   input  wire logic        line_sync_in,
   input  wire logic        strobe_in,
   input  wire logic [23:0] pixel_in,
   output logic             pix_stb_out,
   output logic [23:0]      pix_out,
   output int               frames_out,
   output int               viol_out
);
   localparam int MAXL = (SRC_LINES > DISP_LINES) ? SRC_LINES : DISP_LINES;
   logic pclk_q, hs_p, vs_p, de_p, first, hs_e, vs_e;
   int   bp, fp, vfp;
   always @(posedge sys_clk_in)
   begin
      pix_stb_out = 1'b0;
      if (!resetn_in)
      begin
         {hs_p, vs_p, de_p, first} = 4'h0;
         fp = -1;
         frames_out = 0;
         viol_out = 0;
      end
      else if (pclk_in && !pclk_q)
      begin
         hs_e = (line_sync_in == hs_pol_in) && !hs_p;
         vs_e = (frame_sync_in == vs_pol_in) && !vs_p;
         if (vs_e)
         begin
            vfp = fp;
            bp = 0;
            first = 1'b1;
            frames_out++;
            if (vfp == 0)
               viol_out++;
         end
         else if (hs_e)
            bp++;
         if (hs_e && fp >= 0)
            fp++;
         if (strobe_in && !de_p && first)
         begin
            first = 1'b0;
            if (bp < 2 || (vfp >= 0 &&
                (bp + vfp) * DISP_LINES < 6 * DISP_LINES + 8 * MAXL))
               viol_out++;
         end
         if (!strobe_in && de_p)
            fp = 0;
         pix_stb_out = strobe_in;
         pix_out = pixel_in;
         hs_p = (line_sync_in == hs_pol_in);
         vs_p = (frame_sync_in == vs_pol_in);
         de_p = strobe_in;
      end
      pclk_q = pclk_in;
   end
endmodule

// *** tb/video_source_tb.sv ***
// Self-checking bench for the parallel video source.
// Drives the user side; a display-side model samples the pins.
`timescale 1ns/1ps
module video_source_tb;
   import video_src_pkg::*;
   logic               sys_clk = 1'b0;
   logic               resetn  = 1'b0;
   logic               run     = 1'b0;
   logic               ster    = 1'b0;
   logic               vpol    = 1'b1;
   logic               hpol    = 1'b1;
   logic               eye_q   = 1'b0;
   logic [PIXEL_W-1:0] pix_in  = 24'h000000;
   logic               take, pclk, fs, ls, de, eye, s_stb;
   logic [PIXEL_W-1:0] pbus, s_pix;
   logic [PIXEL_W-1:0] exp_q[$];
   int                 frames, viol, f;
   int                 flips = 0;
   int                 npix = 0;
   int                 ntake = 0;
   int                 seed = 71518;
   int                 error_cnt = 0;
   int                 cmp_count = 0;

   // Other geometry at its defaults; guard spans long enough to stall
   video_source #(.H_ACT(8), .V_ACT(4), .DISP_ACT(4),
      .SETUP_CYC(2000), .HOLD_CYC(2500)) i_dut (
      .sys_clk_in(sys_clk), .resetn_in(resetn), .run_in(run),
      .stereo_en_in(ster), .vs_active_high_in(vpol),
      .hs_active_high_in(hpol), .pixel_data_in(pix_in),
      .pixel_take_out(take), .pclk_out(pclk), .frame_sync_out(fs),
      .line_sync_out(ls), .active_pixel_strobe_out(de),
      .pixel_bus_out(pbus), .stereo_eye_flag_out(eye));
   video_sink i_sink (
      .sys_clk_in(sys_clk), .resetn_in(resetn), .vs_pol_in(vpol),
      .hs_pol_in(hpol), .pclk_in(pclk), .frame_sync_in(fs),
      .line_sync_in(ls), .strobe_in(de), .pixel_in(pbus),
      .pix_stb_out(s_stb), .pix_out(s_pix), .frames_out(frames),
      .viol_out(viol));

   initial forever #50 sys_clk = ~sys_clk;

   function automatic logic [PIXEL_W-1:0] next_pix(input int n);
      logic [PIXEL_W-1:0] c[4] = '{24'h0, 24'hffffff, 24'haaaaaa, 24'h555555};
      return (n < 4) ? c[n] : PIXEL_W'($random(seed));
   endfunction
   function automatic int exp_flips(input int n, input logic en);
      return en ? n : 0;
   endfunction

   task automatic chk_val(input string nm, input logic [31:0] e, g);
      cmp_count++;
      if (e !== g)
      begin
         error_cnt++;
         $display("ERROR %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic chk_pix(input string nm, input logic [PIXEL_W-1:0] e, g);
      cmp_count++;
      if (e !== g)
      begin
         error_cnt++;
         $display("ERROR %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wait_frames(input int n);
      int f0;
      f0 = frames;
      repeat (6000 * n)
      begin
         if (frames >= f0 + n)
            break;
         tick(1);
      end
      chk_val("frames", f0 + n, frames);
   endtask
   task automatic do_reset(input logic vp, input logic hp);
      resetn = 1'b0;
      run = 1'b0;
      vpol = vp;
      hpol = hp;
      tick(3);
      resetn = 1'b1;
      tick(20);
      chk_val("idle sync", {~vp, ~hp}, {fs, ls});
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Records each taken pixel and matches what the display model saw
   always @(posedge sys_clk)
   begin
      #1;
      if (take === 1'b1)
      begin
         exp_q.push_back(pix_in);
         ntake++;
      end
      if (s_stb === 1'b1)
      begin
         npix++;
         if (exp_q.size() == 0)
            chk_val("pixel queue", 1, 0);
         else
            chk_pix("pixel", exp_q.pop_front(), s_pix);
      end
      if (eye !== eye_q)
         flips++;
      eye_q = eye;
      pix_in <= next_pix(ntake);
   end

   initial
   begin
      repeat (80000) @(posedge sys_clk);
      error_cnt++;
      $display("ERROR watchdog expected 0 seen 1");
      results;
   end

   initial
   begin
      do_reset(1'b1, 1'b1);
      run = 1'b1;
      ster = 1'b1;
      wait_frames(1);
      f = flips;
      wait_frames(2);
      chk_val("eye flips", exp_flips(2, ster), flips - f);
      $display("test stereo frames done");
      run = 1'b0;
      ster = 1'b0;
      tick(5000);
      f = frames;
      tick(4000);
      chk_val("idle frames", f, frames);
      chk_val("idle sync", 0, {fs, ls});
      $display("test idle done");
      run = 1'b1;
      wait_frames(2);
      chk_val("eye off", 0, eye);
      $display("test restart done");
      do_reset(1'b0, 1'b0);
      run = 1'b1;
      ster = 1'b1;
      wait_frames(1);
      f = flips;
      wait_frames(2);
      chk_val("eye flips low", exp_flips(2, ster), flips - f);
      $display("test low polarity done");
      chk_val("sink faults", 0, viol);
      chk_val("pixels left", 0, exp_q.size());
      chk_val("pixels seen", 1, npix > 0);
      results;
   end
endmodule
